// >>> giq_pad_model.sv
// Pad model: drives the pin levels seen by the qualification block
`timescale 1ns/10ps
module giq_pad_model (
  input wire logic ref_clk,
  output logic [15:0] pin_in
);
  initial pin_in = 16'h0000;
  // Levels move just after an edge, so the sync stage sees clean levels
  task automatic drive(input int p, input logic v);
    @(posedge ref_clk);
    pin_in[p] <= v;
  endtask
  // Noise pulse shorter than a qualifier window
  task automatic pulse(input int p, input int len);
    drive(p, 1'b1);
    repeat (len) @(posedge ref_clk);
    pin_in[p] <= 1'b0;
  endtask
endmodule // giq_pad_model

// >>> giq_pkg.sv
// Constants for the input qualification block
package giq_pkg;
  localparam int GIQ_ADDR_W = 8;
  localparam int GIQ_PRD_W = 8;
  localparam int GIQ_CNT_W = 9;
  localparam int GIQ_GROUPS = 5;
  localparam int GIQ_GROUP_PINS = 8;
  localparam int GIQ_AIO_N = 6;
  // Register byte offsets
  localparam logic [7:0] GIQ_OFS_CTRL_A = 8'h00;
  localparam logic [7:0] GIQ_OFS_CTRL_B = 8'h04;
  localparam logic [7:0] GIQ_OFS_QSEL_A_LO = 8'h08;
  localparam logic [7:0] GIQ_OFS_AIO = 8'h0c;
  localparam logic [7:0] GIQ_OFS_PROT = 8'h10;
  localparam logic [7:0] GIQ_OFS_QIN = 8'h14;
  // Reset values
  localparam logic [31:0] GIQ_RST_CTRL_A = 32'h0000_0000;
  localparam logic [7:0] GIQ_RST_CTRL_B = 8'h00;
  localparam logic [31:0] GIQ_RST_QSEL = 32'h0000_0000;
  localparam logic [31:0] GIQ_RST_AIO = 32'h2220_2220;
  localparam logic [31:0] GIQ_AIO_MASK = 32'h3330_3330;
  // Low bit of each analog enable field, pins 2,4,6,10,12,14
  localparam int GIQ_AIO_LSB [GIQ_AIO_N] = '{4, 8, 12, 20, 24, 28};
  localparam int GIQ_PROT_BIT = 0;
  // Qualification select codes
  typedef enum logic [1:0] {
    GIQ_SEL_SYNC = 2'h0,
    GIQ_SEL_QUAL3 = 2'h1,
    GIQ_SEL_QUAL6 = 2'h2,
    GIQ_SEL_ASYNC = 2'h3
  } giq_sel_t;
endpackage

// >>> giq_qual.sv
// Input qualification: sample pacing, per-pin qualifiers, config registers
`timescale 1ns/10ps
// Notes on behaviour
// - Analog enable field 00/01 enables, 10/11 disables
// - Control registers set sample spacing for qualifiers
// - Spacing counted in system clock cycles
// - Period 0 gives 1 clock, n gives 2n
// - Port A fields serve pins in groups of eight
// - Port B has one field; upper bits read zero
// - Select register holds two bits per pin 0-15
// - Select 00 synchronises only
// - Select 01 qualifies over 3 samples
// - Select 10 qualifies over 6 samples
// - Select 11 passes pin asynchronously to peripheral
// - Select 11 on general input acts as 00
// - Control and select writes need protected enable
module giq_qual
  import giq_pkg::*;
#(
  parameter int NUM_PINS = 16
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [GIQ_ADDR_W-1:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [31:0] bus_rdata,
  input wire logic [NUM_PINS-1:0] pin_in,
  input wire logic [NUM_PINS-1:0] pin_is_gpio,
  output logic [NUM_PINS-1:0] gpio_in,
  output logic [NUM_PINS-1:0] periph_in,
  output logic [GIQ_GROUPS-1:0] sample_strobe,
  output logic [GIQ_AIO_N-1:0] analog_pin_enable
);

  logic [31:0] ctrl_a_r;
  logic [GIQ_PRD_W-1:0] ctrl_b_r;
  logic [31:0] qsel_r;
  logic [31:0] aio_r;
  logic prot_r;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;

  // Address decode
  wire sel_ctrl_a = (bus_addr == GIQ_OFS_CTRL_A);
  wire sel_ctrl_b = (bus_addr == GIQ_OFS_CTRL_B);
  wire sel_qsel = (bus_addr == GIQ_OFS_QSEL_A_LO);
  wire sel_aio = (bus_addr == GIQ_OFS_AIO);
  wire sel_prot = (bus_addr == GIQ_OFS_PROT);
  wire sel_qin = (bus_addr == GIQ_OFS_QIN);
  // Protected writes are dropped silently, as software expects
  wire wr_prot_ok = bus_wr && prot_r;
  wire wr_ctrl_a = wr_prot_ok && sel_ctrl_a;
  wire wr_ctrl_b = wr_prot_ok && sel_ctrl_b;
  wire wr_qsel = wr_prot_ok && sel_qsel;
  wire wr_aio = bus_wr && sel_aio;
  wire wr_protreg = bus_wr && sel_prot;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_a_r <= GIQ_RST_CTRL_A;
      ctrl_b_r <= GIQ_RST_CTRL_B;
      qsel_r <= GIQ_RST_QSEL;
      aio_r <= GIQ_RST_AIO;
      prot_r <= 1'b0;
    end else begin
      if (wr_ctrl_a) ctrl_a_r <= bus_wdata;
      if (wr_ctrl_b) ctrl_b_r <= bus_wdata[GIQ_PRD_W-1:0];
      if (wr_qsel) qsel_r <= bus_wdata;
      // Reserved analog bits are masked off in case software ignores
      if (wr_aio) aio_r <= bus_wdata & GIQ_AIO_MASK;
      if (wr_protreg) prot_r <= bus_wdata[GIQ_PROT_BIT];
    end
  end

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (bus_rd) begin
      unique case (1'b1)
        sel_ctrl_a: rdata_nxt = ctrl_a_r;
        sel_ctrl_b: rdata_nxt = {24'h00_0000, ctrl_b_r};
        sel_qsel: rdata_nxt = qsel_r;
        sel_aio: rdata_nxt = aio_r;
        sel_prot: rdata_nxt = {31'h0000_0000, prot_r};
        sel_qin: rdata_nxt = 32'(gpio_in);
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) rdata_r <= 32'h0000_0000;
    else rdata_r <= rdata_nxt;
  end
  assign bus_rdata = rdata_r;

  genvar a;
  generate
    for (a = 0; a < GIQ_AIO_N; a++) begin : g_aio
      assign analog_pin_enable[a] = ~aio_r[GIQ_AIO_LSB[a] + 1];
    end
  endgenerate

  // Sample pacing, one counter per group of eight pins
  logic [GIQ_PRD_W-1:0] prd_w [GIQ_GROUPS];
  logic [GIQ_CNT_W-1:0] lim_w [GIQ_GROUPS];
  genvar g;
  generate
    for (g = 0; g < GIQ_GROUPS; g++) begin : g_grp
      logic [GIQ_CNT_W-1:0] cnt_r;
      logic [GIQ_CNT_W-1:0] cnt_nxt;
      if (g < GIQ_GROUPS - 1) begin : g_a
        assign prd_w[g] = ctrl_a_r[g*GIQ_PRD_W +: GIQ_PRD_W];
      end else begin : g_b
        assign prd_w[g] = ctrl_b_r;
      end
      // Zero means every clock, otherwise 2n clocks between strobes
      assign lim_w[g] = (prd_w[g] == 8'h00) ? 9'h000 :
        {prd_w[g], 1'b0} - 9'h001;
      // >= keeps the strobe alive if the period shrinks mid-count
      assign sample_strobe[g] = (cnt_r >= lim_w[g]);
      assign cnt_nxt = sample_strobe[g] ? 9'h000 : cnt_r + 9'h001;
      always_ff @(posedge ref_clk) begin
        if (rst) cnt_r <= 9'h000;
        else cnt_r <= cnt_nxt;
      end
    end
  endgenerate

  // Per-pin synchroniser and qualifier
  logic [5:0] hist_w [NUM_PINS];
  genvar p;
  generate
    for (p = 0; p < NUM_PINS; p++) begin : g_pin
      logic meta_r;
      logic sync_r;
      logic [5:0] hist_r;
      logic q_r;
      logic q_nxt;
      giq_sel_t sel_w;
      wire strb = sample_strobe[p / GIQ_GROUP_PINS];
      wire all1_3 = &hist_r[2:0];
      wire all0_3 = ~|hist_r[2:0];
      wire all1_6 = &hist_r;
      wire all0_6 = ~|hist_r;
      assign sel_w = giq_sel_t'(qsel_r[2*p +: 2]);
      always_comb begin
        q_nxt = q_r;
        unique case (sel_w)
          GIQ_SEL_SYNC: q_nxt = sync_r;
          GIQ_SEL_QUAL3: begin
            if (all1_3) q_nxt = 1'b1;
            else if (all0_3) q_nxt = 1'b0;
          end
          GIQ_SEL_QUAL6: begin
            if (all1_6) q_nxt = 1'b1;
            else if (all0_6) q_nxt = 1'b0;
          end
          GIQ_SEL_ASYNC: q_nxt = sync_r;
        endcase
      end
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          meta_r <= 1'b0;
          sync_r <= 1'b0;
          hist_r <= 6'h00;
          q_r <= 1'b0;
        end else begin
          meta_r <= pin_in[p];
          sync_r <= meta_r;
          if (strb) hist_r <= {hist_r[4:0], sync_r};
          q_r <= q_nxt;
        end
      end
      assign gpio_in[p] = q_r;
      // Async path is only for peripherals; general inputs stay synced
      assign periph_in[p] = (sel_w == GIQ_SEL_ASYNC && !pin_is_gpio[p]) ?
        pin_in[p] : q_r;
      assign hist_w[p] = hist_r;
    end
  endgenerate

  // Checking helpers for group 0 pacing
  logic [GIQ_CNT_W-1:0] gap_r;
  logic clean_r;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      gap_r <= 9'h000;
      clean_r <= 1'b1;
    end else begin
      gap_r <= sample_strobe[0] ? 9'h000 : gap_r + 9'h001;
      if (prd_w[0] != ctrl_a_r[7:0] || wr_ctrl_a) clean_r <= 1'b0;
      else if (sample_strobe[0]) clean_r <= 1'b1;
    end
  end

  // Port B pacing watcher; a period write restarts the comparison
  logic [GIQ_CNT_W-1:0] gap_b_r;
  logic clean_b_r;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      gap_b_r <= 9'h000;
      clean_b_r <= 1'b1;
    end else begin
      gap_b_r <= sample_strobe[4] ? 9'h000 : gap_b_r + 9'h001;
      if (wr_ctrl_b) clean_b_r <= 1'b0;
      else if (sample_strobe[4]) clean_b_r <= 1'b1;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_strobe_spacing: assert property (
    sample_strobe[0] && clean_r && $stable(prd_w[0]) |->
      gap_r == lim_w[0])
    else $error("group 0 strobe spacing wrong");
  a_zero_period: assert property (
    (prd_w[1] == 8'h00) [*2] |-> sample_strobe[1])
    else $error("zero period must strobe every clock");
  // Pin 9 is the pin the bench exercises in every select mode
  a_sync_only: assert property (
    (qsel_r[19:18] == 2'h0) [*4] |-> gpio_in[9] == $past(pin_in[9], 3))
    else $error("sync-only latency wrong");
  a_async_pass: assert property (
    qsel_r[19:18] == 2'h3 && !pin_is_gpio[9] |-> periph_in[9] == pin_in[9])
    else $error("async pass-through broken");
  a_gpio_async_sync: assert property (
    (qsel_r[19:18] == 2'h3 && pin_is_gpio[9]) [*4] |->
      gpio_in[9] == $past(pin_in[9], 3) && periph_in[9] == gpio_in[9])
    else $error("async on gpio must act as sync");
  a_qual3_agree: assert property (
    $past(qsel_r[19:18]) == 2'h1 && $changed(gpio_in[9]) |->
      $past(hist_w[9][2:0]) == {3{gpio_in[9]}})
    else $error("3-sample output changed without agreement");
  a_qual6_agree: assert property (
    $past(qsel_r[19:18]) == 2'h2 && $changed(gpio_in[9]) |->
      $past(hist_w[9]) == {6{gpio_in[9]}})
    else $error("6-sample output changed without agreement");
  a_async_gpio_periph: assert property (
    qsel_r[19:18] == 2'h3 && pin_is_gpio[9] |-> periph_in[9] == gpio_in[9])
    else $error("general input took the async path");
  a_periph_follow: assert property (
    qsel_r[19:18] != 2'h3 |-> periph_in[9] == gpio_in[9])
    else $error("peripheral input differs from qualified input");
  // History moves only on its group strobe, so slow periods stretch it
  a_hist_hold: assert property (
    !sample_strobe[1] |=> $stable(hist_w[9]))
    else $error("history shifted without strobe");
  a_hist_shift: assert property (
    sample_strobe[1] |=> hist_w[9][0] == $past(g_pin[9].sync_r))
    else $error("history missed synced sample");
  a_prot_block: assert property (
    bus_wr && sel_qsel && !prot_r |=> $stable(qsel_r))
    else $error("protected write accepted");
  a_prot_write: assert property (
    bus_wr && sel_ctrl_a && prot_r |=> ctrl_a_r == $past(bus_wdata))
    else $error("enabled write lost");
  a_ctrla_block: assert property (
    bus_wr && sel_ctrl_a && !prot_r |=> $stable(ctrl_a_r))
    else $error("port A period write accepted while locked");
  a_ctrlb_block: assert property (
    bus_wr && sel_ctrl_b && !prot_r |=> $stable(ctrl_b_r))
    else $error("port B period write accepted while locked");
  a_qsel_write: assert property (
    bus_wr && sel_qsel && prot_r |=> qsel_r == $past(bus_wdata))
    else $error("select write lost");
  a_ctrlb_write: assert property (
    bus_wr && sel_ctrl_b && prot_r |=> ctrl_b_r == $past(bus_wdata[7:0]))
    else $error("port B period write lost");
  a_prot_reset: assert property (
    $past(rst) |-> !prot_r)
    else $error("write enable set out of reset");
  // Read data must not linger, or a stale word looks like a new read
  a_rdata_idle: assert property (
    !$past(bus_rd) |-> bus_rdata == 32'h0000_0000)
    else $error("read data outside read cycle");
  a_qin_read: assert property (
    bus_rd && sel_qin |=> bus_rdata[NUM_PINS-1:0] == $past(gpio_in))
    else $error("qualified input readback wrong");
  a_ctrlb_zero: assert property (
    bus_rd && sel_ctrl_b |=> bus_rdata[31:8] == 24'h00_0000)
    else $error("port B reserved bits not zero");
  a_aio_enable: assert property (
    bus_wr && sel_aio && bus_wdata[29:28] == 2'h1 |=>
      analog_pin_enable[5])
    else $error("analog enable code ignored");
  a_aio_disable: assert property (
    bus_wr && sel_aio && bus_wdata[5] |=> !analog_pin_enable[0])
    else $error("analog disable code ignored");
  a_aio_enable_low: assert property (
    bus_wr && sel_aio && !bus_wdata[9] |=> analog_pin_enable[1])
    else $error("analog enable with low code ignored");
  a_aio_reserved: assert property (
    (aio_r & ~GIQ_AIO_MASK) == 32'h0000_0000)
    else $error("reserved analog bits set");
  a_strobe_zero: assert property (
    prd_w[0] == 8'h00 |-> sample_strobe[0])
    else $error("zero period group 0 missed a strobe");
  a_strobe_port_b: assert property (
    ctrl_b_r == 8'h00 |-> sample_strobe[4])
    else $error("zero period port B missed a strobe");
  a_port_b_spacing: assert property (
    sample_strobe[4] && clean_b_r && ctrl_b_r != 8'h00 |->
      gap_b_r + 9'h001 == {ctrl_b_r, 1'b0})
    else $error("port B strobe spacing wrong");
  a_reset_clear: assert property (
    $past(rst) |-> ctrl_a_r == 32'h0000_0000 && qsel_r == 32'h0000_0000)
    else $error("fields not cleared at reset");
  a_gpio_reset: assert property (
    $past(rst) |-> gpio_in == '0 && ctrl_b_r == GIQ_RST_CTRL_B)
    else $error("inputs or port B period not cleared at reset");

  c_qual3: cover property (qsel_r[19:18] == 2'h1 && $changed(gpio_in[9]));
  c_qual6: cover property (qsel_r[19:18] == 2'h2 && $changed(gpio_in[9]));
  c_async: cover property (qsel_r[19:18] == 2'h3 && !pin_is_gpio[9] &&
    $changed(periph_in[9]));
  c_refused: cover property (bus_wr && sel_ctrl_a && !prot_r);
  c_slowest: cover property (sample_strobe[4] && ctrl_b_r == 8'hff);

endmodule // giq_qual

// >>> test_gpio_input_qualification.sv
// Testbench for the input qualification block
`timescale 1ns/10ps
module test_gpio_input_qualification;
  import giq_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] bus_addr = 8'h00;
  logic [31:0] bus_wdata = 32'h0;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [31:0] bus_rdata;
  logic [15:0] pin_in, gpio_in, periph_in;
  logic [15:0] pin_is_gpio = 16'hffff;
  logic [4:0] sample_strobe;
  logic [5:0] analog_pin_enable;
  int failures = 0;
  int tests_run = 0;
  always #2 ref_clk = ~ref_clk;
  giq_qual dut_u (.ref_clk(ref_clk), .rst(rst), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .pin_in(pin_in), .pin_is_gpio(pin_is_gpio),
    .gpio_in(gpio_in), .periph_in(periph_in),
    .sample_strobe(sample_strobe),
    .analog_pin_enable(analog_pin_enable));
  giq_pad_model pad_u (.ref_clk(ref_clk), .pin_in(pin_in));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge ref_clk);
    bus_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge ref_clk);
    bus_rd <= 1'b0;
    #1 chk(bus_rdata, exp);
  endtask
  // Cycles between two strobes of group g, after the config has settled
  task automatic per(input int g, input int v);
    int n;
    n = 0;
    repeat (2) @(negedge ref_clk);
    while (sample_strobe[g] !== 1'b1 && n < 600) begin
      @(negedge ref_clk);
      n++;
    end
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (sample_strobe[g] !== 1'b1 && n < 600);
    chk(n, (v == 0) ? 1 : 2 * v);
  endtask
  task automatic lat(input int p, input int exp);
    int n;
    n = 0;
    pad_u.drive(p, 1'b1);
    while (gpio_in[p] !== 1'b1 && n < 20) begin
      @(posedge ref_clk);
      #1 n++;
    end
    chk(n, exp);
    pad_u.drive(p, 1'b0);
    repeat (12) @(posedge ref_clk);
  endtask
  task automatic glitch(input int p, input int len);
    logic seen;
    seen = 1'b0;
    pad_u.pulse(p, len);
    repeat (12) begin
      @(posedge ref_clk);
      #1 seen |= gpio_in[p];
    end
    chk(seen, 1'b0);
  endtask
  task automatic t_regs();
    chk(analog_pin_enable, 6'h00);
    rd(GIQ_OFS_CTRL_A, 32'h0);
    rd(GIQ_OFS_QSEL_A_LO, 32'h0);
    rd(GIQ_OFS_AIO, GIQ_RST_AIO);
    wr(GIQ_OFS_CTRL_A, 32'h0403_0201);
    rd(GIQ_OFS_CTRL_A, 32'h0);
    wr(GIQ_OFS_PROT, 32'h1);
    wr(GIQ_OFS_QSEL_A_LO, 32'hc6c6_c6c6);
    rd(GIQ_OFS_QSEL_A_LO, 32'hc6c6_c6c6);
    wr(GIQ_OFS_CTRL_B, 32'hffff_ffff);
    rd(GIQ_OFS_CTRL_B, 32'h0000_00ff);
    // Reserved bits written as zero, as software must
    wr(GIQ_OFS_AIO, 32'h1030_2100);
    #1 chk(analog_pin_enable, 6'h33);
    rd(8'h3c, 32'h0);
    $display("register test done");
  endtask
  task automatic t_period();
    for (int n = 0; n < 4; n += 3) begin
      wr(GIQ_OFS_CTRL_A, {8'(n + 3), 8'(n + 2), 8'(n + 1), 8'(n)});
      for (int g = 0; g < 4; g++) per(g, n + g);
    end
    per(4, 255);
    $display("period test done");
  endtask
  task automatic t_modes();
    wr(GIQ_OFS_CTRL_A, 32'h0);
    for (int m = 0; m < 4; m++) begin
      wr(GIQ_OFS_QSEL_A_LO, 32'(m) << 18);
      lat(9, (m == 3) ? 3 : 3 * (m + 1));
    end
    pin_is_gpio[9] <= 1'b0;
    pad_u.drive(9, 1'b1);
    #1 chk(periph_in[9], 1'b1);
    repeat (3) @(posedge ref_clk);
    rd(GIQ_OFS_QIN, 32'h0000_0200);
    pad_u.drive(9, 1'b0);
    pin_is_gpio[9] <= 1'b1;
    repeat (12) @(posedge ref_clk);
    wr(GIQ_OFS_QSEL_A_LO, 32'h1 << 18);
    glitch(9, 2);
    wr(GIQ_OFS_QSEL_A_LO, 32'h2 << 18);
    glitch(9, 5);
    $display("mode test done");
  endtask
  task automatic tally_and_finish();
    $display("tests_run=%0d failures=%0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    t_regs();
    t_period();
    t_modes();
    tally_and_finish();
  end
  // Whole run needs well under 5000 cycles
  initial begin
    #100000;
    failures++;
    tally_and_finish();
  end
endmodule // test_gpio_input_qualification
